// ---- hdl/mepb_pkg.sv ----
// Package: address map, defaults and detector states of the parameter bank
package mepb_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int RAM_DEPTH = 20;
  localparam int RAM_IDX_W = 5;

  // Saved gyroscope offset, upper three bytes of the 96-bit field
  localparam logic [11:0] GYRO_OFS_B9 = 12'h5d5;
  localparam logic [11:0] GYRO_OFS_B10 = 12'h5d6;
  localparam logic [11:0] GYRO_OFS_B11 = 12'h5d7;
  // Saved accelerometer offset, least significant byte first
  localparam logic [11:0] ACCEL_OFS_B0 = 12'h66c;
  localparam int ACCEL_OFS_BYTES = 12;
  localparam logic [11:0] ACCEL_QUALITY = 12'h6b5;
  localparam logic [11:0] FUSION_INIT_FLAG = 12'h6b6;
  localparam logic [11:0] TREE_THRESHOLD_LO = 12'h744;
  localparam logic [11:0] TREE_THRESHOLD_HI = 12'h745;
  localparam logic [11:0] TREE_FEATURE_INDEX = 12'h7c2;
  localparam logic [11:0] TREE_RIGHT_CHILD = 12'h801;
  localparam logic [11:0] TREE_THRESHOLD_SHIFT = 12'h840;
  localparam logic [11:0] CONFIRM_COUNT_B0 = 12'h960;

  // Locations kept in the byte memory, in memory index order
  localparam logic [11:0] RAM_ADDR [RAM_DEPTH] = '{
    GYRO_OFS_B9, GYRO_OFS_B10, GYRO_OFS_B11,
    12'h66c, 12'h66d, 12'h66e, 12'h66f, 12'h670, 12'h671,
    12'h672, 12'h673, 12'h674, 12'h675, 12'h676, 12'h677,
    TREE_THRESHOLD_LO, TREE_THRESHOLD_HI, TREE_FEATURE_INDEX,
    TREE_RIGHT_CHILD, TREE_THRESHOLD_SHIFT
  };

  // Reset defaults, limits and set values of the steering bytes, and the value read at unmapped addresses
  localparam logic [7:0] ACCEL_QUALITY_RST = 8'h00;
  localparam logic [7:0] ACCEL_QUALITY_MAX = 8'h03;
  localparam logic [7:0] FUSION_INIT_RST = 8'h00;
  localparam logic [7:0] FUSION_INIT_DONE = 8'h01;
  localparam logic [7:0] CONFIRM_COUNT_RST = 8'h01;
  localparam logic [7:0] CONFIRM_COUNT_MAX = 8'h03;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    VOICE_QUIET  = 2'b01,
    VOICE_ACTIVE = 2'b10
  } mepb_voice_e;
endpackage

// ---- hdl/mepb_byte_ram.sv ----
// Byte memory with one host read/write port and one engine read port
`timescale 1ns/10ps
module mepb_byte_ram #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 20,
  parameter int IDX_W = 5
) (
  input wire logic clk, // System clock
  input wire logic a_we, // Host write strobe
  input wire logic a_re, // Host read strobe
  input wire logic [IDX_W-1:0] a_idx, // Host location index
  input wire logic [DATA_W-1:0] a_wdata, // Host write data
  output logic [DATA_W-1:0] a_rdata, // Host read data, registered
  input wire logic b_re, // Engine read strobe
  input wire logic [IDX_W-1:0] b_idx, // Engine location index
  output logic [DATA_W-1:0] b_rdata // Engine read data, registered
);
  // No reset: contents stay arbitrary until software loads them
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_idx] <= a_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (a_re) begin
      a_rdata <= mem[a_idx];
    end
  end

  always_ff @(posedge clk) begin
    if (b_re) begin
      b_rdata <= mem[b_idx];
    end
  end
endmodule

// ---- hdl/mepb_param_bank.sv ----
// Motion engine parameter bank with voice vibration confirmation logic
`timescale 1ns/10ps
// Operation
// R1 - Every bank location is one byte, bits 7 to 0, readable and writable by the host.
// R2 - Bank contents are not initialised by reset; the host runs the init procedure first. Here the three steering bytes reset to their defaults.
// R3 - The saved gyro offset is three signed q12 words; its top three bytes live here.
// R4 - The saved accelerometer offset is three signed q16 words, default zero.
// R5 - Multi-byte fields sit least significant byte first, accel offset at 0x66c to 0x677.
// R6 - Accelerometer quality runs from 0 (uncalibrated) to 3 (well calibrated), default 0.
// R7 - The motion processor writes 1 to the fusion init flag when fusion init completes.
// R8 - The host loads the voice decision tree members with the maker's model before use.
// R9 - An event needs this many further consecutive positive decisions, 0 to 3, default 1.
// R10 - Suggested confirm counts are 0 or 1 for keyword spotting, 1 or 2 for transparency.
// R11 - After an event, this many further negatives return the detection state to 0.
module mepb_param_bank #(
  parameter int DATA_W = mepb_pkg::DATA_W,
  parameter int ADDR_W = mepb_pkg::ADDR_W,
  parameter int DEPTH = mepb_pkg::RAM_DEPTH,
  parameter int IDX_W = mepb_pkg::RAM_IDX_W
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic host_wr, // Host write strobe
  input wire logic host_rd, // Host read strobe
  input wire logic [ADDR_W-1:0] host_addr, // Host byte address
  input wire logic [DATA_W-1:0] host_wdata, // Host write data
  output logic [DATA_W-1:0] host_rdata, // Host read data
  output logic host_rvalid, // Host read data valid pulse
  input wire logic eng_rd, // Engine read strobe
  input wire logic [ADDR_W-1:0] eng_addr, // Engine byte address
  output logic [DATA_W-1:0] eng_rdata, // Engine read data
  output logic eng_rvalid, // Engine read data valid pulse
  input wire logic eng_init_done, // Engine pulse: fusion init complete
  output logic fusion_ready, // Init flag currently reads 1
  output logic [1:0] accel_quality, // Accelerometer quality, clamped
  input wire logic vote_valid, // Tree decision strobe
  input wire logic vote_positive, // Tree decision: voice present
  input wire logic [DATA_W-1:0] release_count, // Extra negatives before release
  output logic voice_event, // Event interrupt pulse
  output logic voice_state // Detection state level
);
  logic [DEPTH-1:0] host_sel;
  logic [DEPTH-1:0] eng_sel;
  logic [IDX_W-1:0] host_idx;
  logic [IDX_W-1:0] eng_idx;
  logic host_ram_hit;
  logic eng_ram_hit;
  logic host_rd_go;
  logic host_wr_go;
  logic ram_we;
  logic ram_a_re;
  logic ram_b_re;
  logic [DATA_W-1:0] ram_a_rdata;
  logic [DATA_W-1:0] ram_b_rdata;
  logic [DATA_W-1:0] quality_byte;
  logic [DATA_W-1:0] init_byte;
  logic [DATA_W-1:0] confirm_byte;
  logic [DATA_W-1:0] host_flop_val;
  logic [DATA_W-1:0] eng_flop_val;
  logic [DATA_W-1:0] host_flop_q;
  logic [DATA_W-1:0] eng_flop_q;
  logic host_from_ram;
  logic eng_from_ram;
  logic [1:0] confirm_eff;
  logic [1:0] pos_cnt;
  logic [DATA_W-1:0] neg_cnt;
  mepb_pkg::mepb_voice_e voice_st;
  mepb_pkg::mepb_voice_e next_voice_st;

  // Address decode against the memory-held locations
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_dec
      assign host_sel[gi] = (host_addr == mepb_pkg::RAM_ADDR[gi]);
      assign eng_sel[gi] = (eng_addr == mepb_pkg::RAM_ADDR[gi]);
    end
  endgenerate

  always_comb begin
    host_idx = '0;
    eng_idx = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (host_sel[i]) begin
        host_idx = IDX_W'(i);
      end
      if (eng_sel[i]) begin
        eng_idx = IDX_W'(i);
      end
    end
  end

  assign host_ram_hit = |host_sel;
  assign eng_ram_hit = |eng_sel;
  // A write in the same cycle as a read wins; the read is dropped
  assign host_wr_go = host_wr;
  assign host_rd_go = host_rd && !host_wr;
  assign ram_we = host_wr_go && host_ram_hit; // [R1] [R3] [R4] [R5] [R8]
  assign ram_a_re = host_rd_go && host_ram_hit;
  assign ram_b_re = eng_rd && eng_ram_hit;

  mepb_byte_ram #(
    .DATA_W(DATA_W),
    .DEPTH(DEPTH),
    .IDX_W(IDX_W)
  ) u_ram ( // Bank bytes carry no reset [R2]
    .clk(clk),
    .a_we(ram_we),
    .a_re(ram_a_re),
    .a_idx(host_idx),
    .a_wdata(host_wdata),
    .a_rdata(ram_a_rdata),
    .b_re(ram_b_re),
    .b_idx(eng_idx),
    .b_rdata(ram_b_rdata)
  );

  // Steering bytes held in flops; defaults loaded at reset for a sane start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      quality_byte <= mepb_pkg::ACCEL_QUALITY_RST; // [R6]
    end else if (host_wr_go && host_addr == mepb_pkg::ACCEL_QUALITY) begin
      quality_byte <= host_wdata; // [R1]
    end
  end

  // Engine set beats a host write landing in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_byte <= mepb_pkg::FUSION_INIT_RST;
    end else if (eng_init_done) begin
      init_byte <= mepb_pkg::FUSION_INIT_DONE; // [R7]
    end else if (host_wr_go && host_addr == mepb_pkg::FUSION_INIT_FLAG) begin
      init_byte <= host_wdata; // [R1]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      confirm_byte <= mepb_pkg::CONFIRM_COUNT_RST; // [R9]
    end else if (host_wr_go && host_addr == mepb_pkg::CONFIRM_COUNT_B0) begin
      confirm_byte <= host_wdata; // [R1]
    end
  end

  assign fusion_ready = (init_byte == mepb_pkg::FUSION_INIT_DONE);

  // Values beyond the legal range saturate rather than wrap
  always_comb begin
    if (quality_byte > mepb_pkg::ACCEL_QUALITY_MAX) begin
      accel_quality = 2'h3; // [R6]
    end else begin
      accel_quality = quality_byte[1:0];
    end
  end

  // Raw byte still reads back as written; only its effect saturates
  always_comb begin
    if (confirm_byte > mepb_pkg::CONFIRM_COUNT_MAX) begin
      confirm_eff = 2'h3; // [R9]
    end else begin
      confirm_eff = confirm_byte[1:0];
    end
  end

  // Flop-held locations; any other address outside the memory reads zero
  always_comb begin
    unique case (host_addr)
      mepb_pkg::ACCEL_QUALITY: host_flop_val = quality_byte;
      mepb_pkg::FUSION_INIT_FLAG: host_flop_val = init_byte;
      mepb_pkg::CONFIRM_COUNT_B0: host_flop_val = confirm_byte;
      default: host_flop_val = mepb_pkg::READ_UNMAPPED;
    endcase
  end

  always_comb begin
    unique case (eng_addr)
      mepb_pkg::ACCEL_QUALITY: eng_flop_val = quality_byte;
      mepb_pkg::FUSION_INIT_FLAG: eng_flop_val = init_byte;
      mepb_pkg::CONFIRM_COUNT_B0: eng_flop_val = confirm_byte;
      default: eng_flop_val = mepb_pkg::READ_UNMAPPED;
    endcase
  end

  // Read answers one cycle after the strobe, from whichever store holds it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd_go; // [R1]
    end
  end

  // Source select and flop copy held until the next accepted read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_from_ram <= 1'b0;
      host_flop_q <= '0;
    end else if (host_rd_go) begin
      host_from_ram <= host_ram_hit;
      host_flop_q <= host_flop_val;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eng_rvalid <= 1'b0;
    end else begin
      eng_rvalid <= eng_rd; // [R1]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eng_from_ram <= 1'b0;
      eng_flop_q <= '0;
    end else if (eng_rd) begin
      eng_from_ram <= eng_ram_hit;
      eng_flop_q <= eng_flop_val;
    end
  end

  assign host_rdata = host_from_ram ? ram_a_rdata : host_flop_q;
  assign eng_rdata = eng_from_ram ? ram_b_rdata : eng_flop_q;

  // Detector: count positives while quiet, negatives while active
  // Compare with >= so a count lowered mid-run cannot wrap past it
  always_comb begin
    next_voice_st = voice_st;
    if (vote_valid) begin
      unique case (voice_st)
        mepb_pkg::VOICE_QUIET: begin
          if (vote_positive && pos_cnt >= confirm_eff) begin
            next_voice_st = mepb_pkg::VOICE_ACTIVE; // [R9]
          end
        end
        mepb_pkg::VOICE_ACTIVE: begin
          if (!vote_positive && neg_cnt >= release_count) begin
            next_voice_st = mepb_pkg::VOICE_QUIET; // [R11]
          end
        end
        default: next_voice_st = mepb_pkg::VOICE_QUIET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      voice_st <= mepb_pkg::VOICE_QUIET;
    end else begin
      voice_st <= next_voice_st;
    end
  end

  // A negative breaks the run of positives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_cnt <= 2'h0;
    end else if (vote_valid) begin
      if (!vote_positive || voice_st != mepb_pkg::VOICE_QUIET) begin
        pos_cnt <= 2'h0;
      end else if (pos_cnt >= confirm_eff) begin
        pos_cnt <= 2'h0;
      end else begin
        pos_cnt <= pos_cnt + 2'h1; // [R9]
      end
    end
  end

  // A positive while active restarts the release run
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      neg_cnt <= '0;
    end else if (vote_valid) begin
      if (vote_positive || voice_st != mepb_pkg::VOICE_ACTIVE) begin
        neg_cnt <= '0;
      end else if (neg_cnt >= release_count) begin
        neg_cnt <= '0;
      end else begin
        neg_cnt <= neg_cnt + 8'h01; // [R11]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      voice_event <= 1'b0;
    end else begin
      voice_event <= (voice_st == mepb_pkg::VOICE_QUIET)
                     && (next_voice_st == mepb_pkg::VOICE_ACTIVE); // [R9]
    end
  end

  // Registered copy of the next state so the pin needs no decode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      voice_state <= 1'b0;
    end else begin
      voice_state <= (next_voice_st == mepb_pkg::VOICE_ACTIVE); // [R11]
    end
  end
endmodule

// ---- verification/mepb_param_bank_assertions.sv ----
// Port checker for the parameter bank
`timescale 1ns/10ps
module mepb_param_bank_assertions (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic host_wr, // Write
  input wire logic host_rd, // Read
  input wire logic [11:0] host_addr, // Address
  input wire logic [7:0] host_wdata, // Wdata
  input wire logic host_rvalid, // Rvalid
  input wire logic eng_rd, // Eng read
  input wire logic eng_rvalid, // Eng rvalid
  input wire logic eng_init_done, // Init pulse
  input wire logic fusion_ready, // Ready
  input wire logic [1:0] accel_quality, // Quality
  input wire logic vote_valid, // Vote
  input wire logic vote_positive, // Positive
  input wire logic voice_event, // Event
  input wire logic voice_state // State
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (host_rd && !host_wr |=> host_rvalid)
    else $error("host read not answered");
  rd_drop_a: assert property (host_rd && host_wr |=> !host_rvalid)
    else $error("clashing read answered");
  eng_answer_a: assert property (eng_rd |=> eng_rvalid)
    else $error("engine read not answered");
  init_set_a: assert property (eng_init_done |=> fusion_ready)
    else $error("init flag not set");
  qual_copy_a: assert property (host_wr && host_addr == mepb_pkg::ACCEL_QUALITY
    && host_wdata < 8'h04 |=> accel_quality == $past(host_wdata[1:0]))
    else $error("quality not taken");
  evt_cause_a: assert property (voice_event |-> $past(vote_valid && vote_positive)
    && voice_state)
    else $error("event without positive vote");
  evt_quiet_a: assert property (voice_event |-> !$past(voice_state))
    else $error("event while active");
  release_a: assert property ($fell(voice_state) |-> $past(vote_valid && !vote_positive))
    else $error("release without negative vote");
endmodule

bind mepb_param_bank mepb_param_bank_assertions u_chk (
  .clk(clk), .sys_rst(sys_rst), .host_wr(host_wr), .host_rd(host_rd),
  .host_addr(host_addr), .host_wdata(host_wdata), .host_rvalid(host_rvalid),
  .eng_rd(eng_rd), .eng_rvalid(eng_rvalid), .eng_init_done(eng_init_done),
  .fusion_ready(fusion_ready), .accel_quality(accel_quality), .vote_valid(vote_valid),
  .vote_positive(vote_positive), .voice_event(voice_event), .voice_state(voice_state)
);

// ---- verification/mepb_host_model.sv ----
// Host processor model on the bank's host port
`timescale 1ns/10ps
module mepb_host_model (
  input wire logic clk, // Clock
  output logic host_wr, // Write
  output logic host_rd, // Read
  output logic [11:0] host_addr, // Address
  output logic [7:0] host_wdata, // Wdata
  input wire logic [7:0] host_rdata, // Rdata
  input wire logic host_rvalid // Rvalid
);
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 12'h000;
    host_wdata = 8'h00;
  end
  task automatic acc(input bit w, input bit r, input logic [11:0] a,
                     input logic [7:0] wd, output logic [7:0] d, output logic v);
    @(negedge clk);
    host_wr = w;
    host_rd = r;
    host_addr = a;
    host_wdata = wd;
    @(negedge clk);
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = ~wd; // No stale data once released
    d = host_rdata;
    v = host_rvalid;
  endtask
  // Bank is random until this runs
  task automatic init();
    logic [7:0] d;
    logic v;
    for (int i = 0; i < 15; i++) acc(1, 0, mepb_pkg::RAM_ADDR[i], 8'h00, d, v);
    for (int i = 15; i < 20; i++) acc(1, 0, mepb_pkg::RAM_ADDR[i], 8'(8'h40 + i), d, v);
    acc(1, 0, mepb_pkg::CONFIRM_COUNT_B0, 8'h01, d, v); // Keyword spotting pick
  endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench of the parameter bank
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic host_wr, host_rd, host_rvalid, eng_rvalid, fusion_ready, voice_event, voice_state;
  logic [11:0] host_addr;
  logic [7:0] host_wdata, host_rdata, eng_rdata, d;
  logic [1:0] accel_quality;
  logic eng_rd = 1'b0;
  logic [11:0] eng_addr = 12'h000;
  logic eng_init_done = 1'b0;
  logic vote_valid = 1'b0;
  logic vote_positive = 1'b0;
  logic [7:0] release_count = 8'h00;
  logic v;
  int failures = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  mepb_param_bank DUT (.clk(clk), .sys_rst(sys_rst), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .eng_rd(eng_rd), .eng_addr(eng_addr), .eng_rdata(eng_rdata),
    .eng_rvalid(eng_rvalid), .eng_init_done(eng_init_done), .fusion_ready(fusion_ready),
    .accel_quality(accel_quality), .vote_valid(vote_valid), .vote_positive(vote_positive),
    .release_count(release_count), .voice_event(voice_event), .voice_state(voice_state));
  mepb_host_model HOST (.clk(clk), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] wd);
    HOST.acc(1, 0, a, wd, d, v);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    HOST.acc(0, 1, a, 8'h00, d, v);
    chk("rvalid", {7'h00, v}, 8'h01);
    chk("rdata", d, exp);
  endtask
  task automatic erd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    eng_rd = 1'b1;
    eng_addr = a;
    @(negedge clk);
    eng_rd = 1'b0;
    chk("eng_rvalid", {7'h00, eng_rvalid}, 8'h01);
    chk("eng_rdata", eng_rdata, exp);
  endtask
  task automatic t_defaults();
    rd(mepb_pkg::ACCEL_QUALITY, 8'h00);
    rd(mepb_pkg::FUSION_INIT_FLAG, 8'h00);
    rd(mepb_pkg::CONFIRM_COUNT_B0, 8'h01);
    chk("ready", {7'h00, fusion_ready}, 8'h00);
    HOST.init();
    rd(mepb_pkg::GYRO_OFS_B9, 8'h00);
    rd(mepb_pkg::ACCEL_OFS_B0, 8'h00);
    rd(mepb_pkg::TREE_FEATURE_INDEX, 8'h51);
  endtask
  task automatic t_bytes();
    logic [95:0] ofs = 96'hfedcba98_76543210_0f1e2d3c;
    for (int i = 0; i < 12; i++) wr(12'(mepb_pkg::ACCEL_OFS_B0 + i), ofs[8*i +: 8]);
    for (int i = 0; i < 12; i++) rd(12'(mepb_pkg::ACCEL_OFS_B0 + i), ofs[8*i +: 8]);
    wr(mepb_pkg::GYRO_OFS_B11, 8'h9f);
    rd(mepb_pkg::GYRO_OFS_B11, 8'h9f);
    wr(mepb_pkg::TREE_THRESHOLD_SHIFT, 8'hff);
    rd(mepb_pkg::TREE_THRESHOLD_SHIFT, 8'hff);
    erd(12'h677, 8'hfe);
    erd(mepb_pkg::CONFIRM_COUNT_B0, 8'h01);
    wr(12'h961, 8'h55);
    rd(12'h961, 8'h00); // Unmapped
    HOST.acc(1, 1, mepb_pkg::TREE_THRESHOLD_LO, 8'h77, d, v);
    chk("clash", {7'h00, v}, 8'h00);
    rd(mepb_pkg::TREE_THRESHOLD_LO, 8'h77);
  endtask
  task automatic t_init();
    fork
      wr(mepb_pkg::FUSION_INIT_FLAG, 8'h00);
      begin
        @(negedge clk);
        eng_init_done = 1'b1;
        @(negedge clk);
        eng_init_done = 1'b0;
      end
    join
    chk("ready", {7'h00, fusion_ready}, 8'h01); // Engine wins
    rd(mepb_pkg::FUSION_INIT_FLAG, 8'h01);
    wr(mepb_pkg::FUSION_INIT_FLAG, 8'h00);
    chk("ready", {7'h00, fusion_ready}, 8'h00);
  endtask
  task automatic t_quality();
    for (int q = 0; q < 5; q++) begin
      wr(mepb_pkg::ACCEL_QUALITY, (q == 4) ? 8'h07 : 8'(q));
      chk("quality", {6'h00, accel_quality}, (q == 4) ? 8'h03 : 8'(q));
      rd(mepb_pkg::ACCEL_QUALITY, (q == 4) ? 8'h07 : 8'(q));
    end
  endtask
  task automatic vote(input bit p, input bit ev, input bit st);
    @(negedge clk);
    vote_valid = 1'b1;
    vote_positive = p;
    @(negedge clk);
    vote_valid = 1'b0;
    vote_positive = ~p;
    chk("event", {7'h00, voice_event}, {7'h00, ev});
    chk("state", {7'h00, voice_state}, {7'h00, st});
  endtask
  task automatic t_detect(input logic [7:0] cb, input int c);
    wr(mepb_pkg::CONFIRM_COUNT_B0, cb);
    rd(mepb_pkg::CONFIRM_COUNT_B0, cb);
    release_count = 8'(3 - c);
    repeat (c) vote(1, 0, 0);
    vote(1, 1, 1);
    vote(1, 0, 1); // No second event
    repeat (3 - c) vote(0, 0, 1);
    vote(0, 0, 0);
  endtask
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    t_defaults();
    t_bytes();
    t_init();
    t_quality();
    for (int c = 0; c < 4; c++) t_detect(8'(c), c);
    t_detect(8'h09, 3); // Out-of-range byte acts as 3
    print_verdict();
  end
endmodule
